/* File: common/tls_map.vh */
// constants for the travel limit stop logic
// assumes inclusion by rtl/tls_limit.v only
`ifndef TLS_MAP_VH
`define TLS_MAP_VH
`define TLS_CFG_ADDR 16'h0080
`define TLS_POL_BIT 0
`define TLS_MODE_LO 1
`define TLS_MODE_HI 2
`define TLS_MODE_LEVEL 2'h0
`define TLS_MODE_FALL 2'h1
`define TLS_MODE_RISE 2'h2
`define TLS_PAUSE_CYC 32'h00000FA0
`define TLS_CFG_RST 3'h0
`define TLS_CH_FWD 0
`define TLS_CH_REV 1
`define TLS_NUM_CH 2
`define TLS_CNT_W 32
`define TLS_SYNC_RST 2'h3
`define TLS_IDLE_LVL 1'h1
`endif

/* File: rtl/tls_limit.v */
// travel limit supervision: forward/reverse limit inputs gate motion
// assumes limit inputs are levels asynchronous to sys_clk
// assumes pull-ups on both limit pins, contacts to a common return
// assumes cfg is written by the serial link through cfg_wr/cfg_addr
`timescale 1ns/10ps
`include "tls_map.vh"
module tls_limit #(
    parameter PAUSE_CYC = `TLS_PAUSE_CYC
) (
    input wire sys_clk,
    input wire nrst,
    input wire forward_limit_input,
    input wire reverse_limit_input,
    input wire cfg_wr,
    input wire [15:0] cfg_addr,
    input wire [2:0] cfg_wdata,
    input wire run_fwd,
    input wire run_rev,
    output reg [2:0] cfg_q,
    output reg motor_enable_q,
    output reg fwd_stop_q,
    output reg rev_stop_q,
    output reg pause_q
);
    // channel 0 is forward travel, channel 1 reverse
    localparam FWD = `TLS_CH_FWD;
    localparam REV = `TLS_CH_REV;
    localparam NCH = `TLS_NUM_CH;
    // counter wide enough for any 32-bit pause count
    localparam CNT_W = `TLS_CNT_W;
    localparam [CNT_W-1:0] CNT_ZERO = {CNT_W{1'h0}};
    localparam [CNT_W-1:0] CNT_ONE = {{(CNT_W-1){1'h0}}, 1'h1};
    localparam [CNT_W-1:0] PAUSE_LOAD = PAUSE_CYC - 1;

    // active level of a limit under the chosen polarity
    function lim_active;
        input pol;
        input lvl;
        begin
            lim_active = pol ? lvl : ~lvl;
        end
    endfunction

    // falling and rising codes both arm the held stop
    function mode_is_edge;
        input [1:0] m;
        begin
            mode_is_edge = (m == `TLS_MODE_FALL) || (m == `TLS_MODE_RISE);
        end
    endfunction

    wire pol_high;
    wire [1:0] mode;
    wire edge_mode;
    wire cfg_hit;

    // per-channel vectors, bit 0 forward
    wire [NCH-1:0] lim_raw;
    wire [NCH-1:0] run_dir;
    wire [NCH-1:0] run_opp;
    wire [NCH-1:0] lim_act;
    wire [NCH-1:0] lim_start;
    wire [NCH-1:0] lim_end;
    wire [NCH-1:0] hold;
    wire [NCH-1:0] arm;
    wire [NCH-1:0] block;

    wire any_run;
    wire any_block;
    wire pause_go;
    wire pause_done;
    reg pause_d;
    reg [CNT_W-1:0] pause_cnt_d;
    reg [CNT_W-1:0] pause_cnt_q;
    reg motor_enable_d;

    assign pol_high = cfg_q[`TLS_POL_BIT];
    assign mode = cfg_q[`TLS_MODE_HI:`TLS_MODE_LO];
    // the unused mode code falls back to level behaviour
    assign edge_mode = mode_is_edge(mode);
    // only the config address is taken
    assign cfg_hit = cfg_wr && (cfg_addr == `TLS_CFG_ADDR);
    assign lim_raw = {reverse_limit_input, forward_limit_input};
    assign run_dir = {run_rev, run_fwd};
    assign run_opp = {run_fwd, run_rev};

    // config register, normally open default
    // writes to any other address are dropped silently
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cfg_q <= `TLS_CFG_RST;
        end else if (cfg_hit) begin
            cfg_q <= cfg_wdata;
        end
    end

    // one copy per limit: synchronise, find edges,
    // remember activation for the pause, hold in edge mode;
    // the two channels never look at each other's pin
    genvar ch;
    generate
        for (ch = 0; ch < NCH; ch = ch + 1) begin : g_ch
            reg [1:0] sync_q;
            reg prev_q;
            reg arm_q;
            reg hold_q;
            wire lvl_s;
            wire act_now;
            wire act_prev;

            // two-stage synchroniser per limit
            // reset to the pulled-up idle level, so no false edge
            always @(posedge sys_clk or negedge nrst) begin
                if (!nrst) begin
                    sync_q <= `TLS_SYNC_RST;
                end else begin
                    sync_q <= {sync_q[0], lim_raw[ch]};
                end
            end
            assign lvl_s = sync_q[1];

            // active level by polarity
            // prev holds the raw level, so a polarity write
            // changes both sides together and makes no edge
            assign act_now = lim_active(pol_high, lvl_s);
            assign act_prev = lim_active(pol_high, prev_q);
            assign lim_act[ch] = act_now;
            assign lim_start[ch] = ~act_prev & act_now;
            assign lim_end[ch] = act_prev & ~act_now;

            always @(posedge sys_clk or negedge nrst) begin
                if (!nrst) begin
                    prev_q <= `TLS_IDLE_LVL;
                    arm_q <= 1'h0;
                    hold_q <= 1'h0;
                end else begin
                    prev_q <= lvl_s;
                    arm_q <= run_dir[ch] &
                             (lim_start[ch] | (arm_q & ~lim_end[ch]));
                    // edge stop held until opposite
                    // set wins over a clear in the same cycle
                    if (edge_mode && run_dir[ch] && lim_start[ch]) begin
                        hold_q <= 1'h1;
                    end else if (run_opp[ch] || !edge_mode) begin
                        hold_q <= 1'h0;
                    end
                end
            end
            assign arm[ch] = arm_q;
            assign hold[ch] = hold_q;

            // each limit gates only its own direction
            assign block[ch] = run_dir[ch] & (act_now | hold_q);
        end
    endgenerate

    assign any_run = |run_dir;
    assign any_block = |block;

    // release after a level-mode stop pauses
    assign pause_go = ~edge_mode & (|(arm & lim_end & run_dir));
    assign pause_done = pause_q && (pause_cnt_q == CNT_ZERO);

    // pause lasts PAUSE_CYC cycles from the load
    // a fresh release during a pause restarts the count
    always @* begin
        pause_d = pause_q;
        pause_cnt_d = pause_cnt_q;
        if (pause_go) begin
            pause_d = 1'h1;
            pause_cnt_d = PAUSE_LOAD;
        end else if (pause_q) begin
            if (pause_done) begin
                pause_d = 1'h0;
            end else begin
                pause_cnt_d = pause_cnt_q - CNT_ONE;
            end
        end
    end

    // enable drops with the stop and returns once stop and pause clear
    // pause is taken from its next value so that the
    // motor never runs for one cycle between stop and pause
    always @* begin
        motor_enable_d = any_run & ~any_block & ~pause_d;
    end

    // all outputs registered; stop flags trail the inputs
    // by the two synchroniser stages plus this one
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            pause_cnt_q <= CNT_ZERO;
            pause_q <= 1'h0;
            fwd_stop_q <= 1'h0;
            rev_stop_q <= 1'h0;
            motor_enable_q <= 1'h0;
        end else begin
            pause_cnt_q <= pause_cnt_d;
            pause_q <= pause_d;
            fwd_stop_q <= block[FWD];
            rev_stop_q <= block[REV];
            motor_enable_q <= motor_enable_d;
        end
    end
endmodule // tls_limit

/* File: bench/tls_sw.sv */
// two limit contacts on a common return, pull-ups on both inputs
`timescale 1ns/10ps
module tls_sw (input wire cf, cr, output wire fl, rl);
// open contact floats up, closed sinks to common
assign fl = !cf;
assign rl = !cr;
endmodule // tls_sw

/* File: bench/tls_chk.sv */
// port checker, bound into every tls_limit below
`timescale 1ns/10ps
module tls_chk (input wire sys_clk, nrst, cfg_wr, run_fwd, run_rev,
forward_limit_input, reverse_limit_input, motor_enable_q, fwd_stop_q,
rev_stop_q, pause_q, input wire [15:0] cfg_addr,
input wire [2:0] cfg_wdata, cfg_q);
wire f = forward_limit_input, r = reverse_limit_input;
wire lo = cfg_q == 3'h0, hit = cfg_wr && cfg_addr == 16'h0080;
wire e2 = cfg_q == 3'h2 && !cfg_wr, hi = cfg_q == 3'h1;
default clocking @(posedge sys_clk); endclocking
default disable iff (!nrst);
property p_wr; hit |=> cfg_q == $past(cfg_wdata); endproperty
a_wr: assert property (p_wr) else $error("wr");
property p_fl; (lo && run_fwd && !f) [*4] |-> fwd_stop_q; endproperty
a_fl: assert property (p_fl) else $error("fl");
property p_fh; (hi && run_fwd && f) [*4] |-> fwd_stop_q; endproperty
a_fh: assert property (p_fh) else $error("fh");
property p_rl; (lo && run_rev && !r) [*4] |-> rev_stop_q; endproperty
a_rl: assert property (p_rl) else $error("rl");
property p_rx; (lo && r) [*4] |-> !rev_stop_q; endproperty
a_rx: assert property (p_rx) else $error("rx");
property p_pe; pause_q |-> !motor_enable_q; endproperty
a_pe: assert property (p_pe) else $error("pe");
// eight cycles high with the bench pause count of 8
property p_pz; $rose(pause_q) |-> pause_q[*8] ##1 $fell(pause_q); endproperty
a_pz: assert property (p_pz) else $error("pz");
property p_hd; fwd_stop_q && e2 && !run_rev |=> fwd_stop_q; endproperty
a_hd: assert property (p_hd) else $error("hd");
endmodule // tls_chk
bind tls_limit tls_chk u_chk (.sys_clk(sys_clk), .nrst(nrst),
    .cfg_wr(cfg_wr), .run_fwd(run_fwd), .run_rev(run_rev),
    .forward_limit_input(forward_limit_input),
    .reverse_limit_input(reverse_limit_input),
    .motor_enable_q(motor_enable_q), .fwd_stop_q(fwd_stop_q),
    .rev_stop_q(rev_stop_q), .pause_q(pause_q), .cfg_addr(cfg_addr),
    .cfg_wdata(cfg_wdata), .cfg_q(cfg_q));

/* File: bench/testbench.sv */
// limit block bench: level table, then pause and edge holds
`timescale 1ns/10ps
module testbench;
reg sys_clk = 0, nrst = 0, cfg_wr = 0, run_fwd = 0, run_rev = 0;
reg cf = 0, cr = 0;
reg [15:0] cfg_addr = 16'h0;
reg [2:0] cfg_wdata = 3'h0;
wire forward_limit_input, reverse_limit_input, motor_enable_q, fwd_stop_q;
wire rev_stop_q, pause_q;
wire [2:0] cfg_q;
integer failures = 0, compares = 0, i, n = 0;
// rows: cfg, fwd, rev, contact f, contact r, enable
reg [7:0] t [0:5] = '{8'h14, 8'h13, 8'h0A, 8'h0D, 8'h30, 8'h35};
tls_sw SW (.cf, .cr, .fl(forward_limit_input), .rl(reverse_limit_input));
tls_limit #(.PAUSE_CYC(8)) DUT (.sys_clk(sys_clk), .nrst(nrst),
    .forward_limit_input(forward_limit_input),
    .reverse_limit_input(reverse_limit_input), .cfg_wr(cfg_wr),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .run_fwd(run_fwd),
    .run_rev(run_rev), .cfg_q(cfg_q), .motor_enable_q(motor_enable_q),
    .fwd_stop_q(fwd_stop_q), .rev_stop_q(rev_stop_q), .pause_q(pause_q));
initial forever #2.5 sys_clk = ~sys_clk;
always @(posedge sys_clk) if (++n > 900) begin failures++; finish_test; end
task chk(input [2:0] s, e, input string m); begin compares++;
    if (s !== e) begin
        failures++;
        $display("BAD %s exp %h got %h", m, e, s);
    end
end endtask
task wr(input [2:0] d, input [15:0] a = 16'h0080); begin
    @(posedge sys_clk) {cfg_wr, cfg_addr, cfg_wdata} <= {1'h1, a, d};
    @(posedge sys_clk) cfg_wr <= 1'h0;
end endtask
// sample at the falling edge so registered outputs have settled
task go(input [3:0] v, input integer k); begin
    @(posedge sys_clk) {run_fwd, run_rev, cf, cr} <= v;
    repeat (k) @(posedge sys_clk);
    @(negedge sys_clk);
end endtask
task finish_test; begin
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
end endtask
initial begin
    repeat (6) @(posedge sys_clk);
    chk(motor_enable_q, 1'h0, "reset en");
    nrst <= 1'h1;
    chk(cfg_q, 3'h0, "reset cfg");
    $display("reset test done");
    for (i = 0; i < 6; i++) begin
        wr(t[i][7:5]); go(t[i][4:1], 20);
        chk(motor_enable_q, t[i][0], "row en");
        $display("row %0d done", i);
    end
    wr(3'h0); go(4'b1000, 20); go(4'b1010, 8); go(4'b1000, 6);
    chk(pause_q, 1'h1, "pause");
    wr(3'h2); go(4'b1010, 8); go(4'b1000, 20);
    chk(fwd_stop_q, 1'h1, "fwd hold");
    go(4'b0100, 20);
    chk(motor_enable_q, 1'h1, "released");
    wr(3'h4); go(4'b0101, 8); go(4'b0100, 20);
    chk(rev_stop_q, 1'h1, "rev hold");
    wr(3'h7, 16'h0081); go(4'b1000, 2);
    chk(cfg_q, 3'h4, "stray write");
    $display("edge and pause tests done");
    finish_test;
end
endmodule // testbench
